// ---- hw/qss_device.sv ----
// converter end: simultaneous hold, channel sequencer, successive
// approximation core and parallel read port
// assumes the analogue inputs arrive as sampled codes on ain
`default_nettype none
module qss_device
	import qss_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire logic                   ce,
	input  wire logic [NCH-1:0][DATA_W-1:0] ain,
	output logic [NCH-1:0]              hold,
	qss_if.dev                          bus
);
	typedef enum logic [1:0] {QSS_IDLE, QSS_CONV, QSS_PUSH} qss_state_t;

	qss_state_t          state;
	logic [12:0]         sync1;
	logic [12:0]         sync2;
	logic                trig_prev;
	logic                rd_prev;
	logic [3:0]          chan_reg;
	logic [NCH-1:0]      remain;
	logic [1:0]          ch;
	logic [NCH-1:0][DATA_W-1:0] held;
	logic [DATA_W-1:0]   sar;
	logic [3:0]          bitpos;
	logic                sar_done;
	logic [7:0]          cyc;
	logic [3:0]          step;
	logic                busy;
	logic                eoc;
	logic [DATA_W-1:0]   db_q;
	logic                db_oe;

	// pin inputs after two flops
	wire                 trig_s  = sync2[12];
	wire                 cs_n_s  = sync2[11];
	wire                 rd_n_s  = sync2[10];
	wire                 wr_n_s  = sync2[9];
	wire                 hwsel_s = sync2[8];
	wire [3:0]           pins_s  = sync2[7:4];
	wire [3:0]           db_s    = sync2[3:0];

	wire                 trig_edge = trig_s & ~trig_prev;
	wire                 rd_act    = ~cs_n_s & ~rd_n_s;
	wire                 rd_start  = rd_act & ~rd_prev;
	wire                 rd_end    = ~rd_act & rd_prev;
	wire                 wr_act    = ~cs_n_s & ~wr_n_s;
	wire [NCH-1:0]       sel       = hwsel_s ? pins_s : chan_reg;
	wire                 start     = (state == QSS_IDLE) && trig_edge && (sel != 4'h0);
	wire [NCH-1:0]       src       = start ? sel : remain;
	wire [1:0]           first_ch  = lowest(src);
	wire [NCH-1:0]       left      = remain & ~(4'h1 << ch);
	wire [DATA_W-1:0]    trial     = sar | (12'h001 << bitpos);
	wire [DATA_W-1:0]    sample    = held[ch];
	wire                 step_hit  = step == 4'(STEP_CYC - 1);
	wire                 conv_end  = cyc == 8'(CONV_CYC - 1);
	wire                 fifo_in_ready;
	wire                 fifo_out_valid;
	wire [DATA_W-1:0]    fifo_out_data;
	wire                 push_ok   = (state == QSS_PUSH) && fifo_in_ready;

	function automatic logic [1:0] lowest(input logic [NCH-1:0] m);
		logic [1:0] r;
		r = 2'd3;
		for (int i = NCH - 1; i >= 0; i--)
			if (m[i])
				r = 2'(i);
		return r;
	endfunction : lowest

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			sync1 <= SYNC_RST;
			sync2 <= SYNC_RST;
		end
		else if (ce)
		begin
			sync1 <= {bus.conversion_trigger, bus.cs_n, bus.rd_n, bus.wr_n,
				bus.hw_sel, bus.sel_pins, bus.db[3:0]};
			sync2 <= sync1;
		end

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			trig_prev <= 1'b0;
			rd_prev   <= 1'b0;
		end
		else if (ce)
		begin
			trig_prev <= trig_s;
			rd_prev   <= rd_act;
		end

	// register copy of the channel set, loaded while the write strobe is low
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			chan_reg <= CHAN_RST;
		else if (ce && wr_act)
			chan_reg <= db_s;

	// all four inputs go to hold on one edge
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			hold <= '0;
		else if (ce)
		begin
			if (start)
				hold <= '1;
			else if (push_ok && left == '0)
				hold <= '0;
		end

	always_ff @(posedge clk)
		if (ce && start)
			held <= ain;

	// sequencer: walks the selected channels lowest first
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			state  <= QSS_IDLE;
			remain <= '0;
			ch     <= 2'd0;
			busy   <= 1'b0;
			eoc    <= 1'b0;
		end
		else if (ce)
		begin
			eoc <= 1'b0;
			unique case (state)
				QSS_IDLE:
					if (start)
					begin
						remain <= sel;
						ch     <= first_ch;
						busy   <= 1'b1;
						state  <= QSS_CONV;
					end
				QSS_CONV:
					if (conv_end)
						state <= QSS_PUSH;
				QSS_PUSH:
					if (fifo_in_ready)
					begin
						eoc    <= 1'b1;
						remain <= left;
						ch     <= lowest(left);
						if (left == '0)
						begin
							busy  <= 1'b0;
							state <= QSS_IDLE;
						end
						else
							state <= QSS_CONV;
					end
			endcase
		end

	// successive approximation, one bit per step, restarted per channel
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			sar      <= '0;
			bitpos   <= 4'd11;
			sar_done <= 1'b0;
			cyc      <= '0;
			step     <= '0;
		end
		else if (ce)
		begin
			if (state != QSS_CONV)
			begin
				// cleared on the push edge so the next channel starts from zero
				sar      <= (state == QSS_PUSH && !fifo_in_ready) ? sar : '0;
				bitpos   <= 4'(DATA_W - 1);
				sar_done <= 1'b0;
				cyc      <= '0;
				step     <= '0;
			end
			else
			begin
				cyc  <= cyc + 8'd1;
				step <= step_hit ? 4'd0 : step + 4'd1;
				if (step_hit && !sar_done)
				begin
					if (trial <= sample)
						sar <= trial;
					if (bitpos == 4'd0)
						sar_done <= 1'b1;
					else
						bitpos <= bitpos - 4'd1;
				end
			end
		end

	// results queue in conversion order, one pop per finished read
	qss_fifo #(
		.W (DATA_W),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.ce        (ce),
		.in_valid  (state == QSS_PUSH),
		.in_ready  (fifo_in_ready),
		.in_data   (sar),
		.out_valid (fifo_out_valid),
		.out_ready (rd_end),
		.out_data  (fifo_out_data)
	);

	// read port: word latched at strobe start, bus released at its end
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			db_q  <= '0;
			db_oe <= 1'b0;
		end
		else if (ce)
		begin
			if (rd_start)
			begin
				db_q  <= fifo_out_valid ? fifo_out_data : '0;
				db_oe <= 1'b1;
			end
			else if (rd_end)
				db_oe <= 1'b0;
		end

	assign bus.busy      = busy;
	assign bus.eoc       = eoc;
	assign bus.db_dev    = db_q;
	assign bus.db_dev_oe = db_oe;
endmodule : qss_device
`default_nettype wire

// ---- hw/qss_pkg.sv ----
// constants shared by both ends of the four-channel sampling converter link
// assumes one 50 MHz clock drives both ends
// Operation
// - Trigger holds all four inputs, starts sequence
// - Done pulse after every finished conversion
// - Busy stays high until last channel converted
// - Only selected channels converted, others skipped
// - Channel set from pins or written register
// - Each channel converted within conversion time
// - Host waits acquisition time before next trigger
// - Result read as 12-bit word under strobes
// - Single channel trigger rate kept under limit
// - Four channel trigger rate kept under limit
// - Read during or after the sequence
`default_nettype none
package qss_pkg;
	localparam int          DATA_W      = 12;
	localparam int          NCH         = 4;
	localparam int          FIFO_DEPTH  = 8;
	localparam int          CLK_MHZ     = 50;
	localparam int          CONV_NS     = 1650;
	localparam int          ACQ_NS      = 350;
	localparam int          SINGLE_KSPS = 500;
	localparam int          QUAD_KSPS   = 130;
	// longest time rounds down, least times round up
	localparam int          CONV_CYC    = CONV_NS * CLK_MHZ / 1000;
	localparam int          STEP_CYC    = CONV_CYC / DATA_W;
	localparam int          ACQ_CYC     = (ACQ_NS * CLK_MHZ + 999) / 1000;
	localparam int          SINGLE_CYC  = (CLK_MHZ * 1000 + SINGLE_KSPS - 1) / SINGLE_KSPS;
	localparam int          QUAD_CYC    = (CLK_MHZ * 1000 + QUAD_KSPS - 1) / QUAD_KSPS;
	localparam int          STROBE_CYC  = 8;
	localparam int          TRIG_CYC    = 4;
	localparam logic [3:0]  CHAN_RST    = 4'hf;
	// synchroniser reset: strobes idle high, everything else low
	localparam logic [12:0] SYNC_RST    = 13'h0e00;
endpackage : qss_pkg
`default_nettype wire

// ---- hw/qss_if.sv ----
// pin-level link between the converter end and the host end
// assumes the bench or top level instantiates it and joins the two ends
`default_nettype none
interface qss_if;
	logic        conversion_trigger;
	logic        cs_n;
	logic        rd_n;
	logic        wr_n;
	logic        hw_sel;
	logic [3:0]  sel_pins;
	logic        busy;
	logic        eoc;
	logic [11:0] db_dev;
	logic        db_dev_oe;
	logic [11:0] db_host;
	logic        db_host_oe;
	logic [11:0] db;

	// resolved data bus level, undriven reads as zero
	assign db = db_dev_oe ? db_dev : (db_host_oe ? db_host : 12'h000);

	modport dev (
		input  conversion_trigger, cs_n, rd_n, wr_n, hw_sel, sel_pins, db,
		output busy, eoc, db_dev, db_dev_oe
	);
	modport host (
		output conversion_trigger, cs_n, rd_n, wr_n, hw_sel, sel_pins, db_host, db_host_oe,
		input  busy, eoc, db
	);
endinterface : qss_if
`default_nettype wire

// ---- hw/qss_fifo.sv ----
// result buffer between the converter core and the read port
// assumes depth is a power of two and both sides share clk
`default_nettype none
module qss_fifo
	import qss_pkg::*;
#(
	parameter int W = DATA_W,
	parameter int D = FIFO_DEPTH
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         ce,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW:0]  wptr;
	logic [AW:0]  rptr;
	wire          push = in_valid & in_ready;
	wire          pop  = out_valid & out_ready;

	assign in_ready  = (wptr - rptr) != (AW+1)'(D);
	assign out_valid = wptr != rptr;
	assign out_data  = mem[rptr[AW-1:0]];

	always_ff @(posedge clk)
		if (ce && push)
			mem[wptr[AW-1:0]] <= in_data;

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			wptr <= '0;
			rptr <= '0;
		end
		else if (ce)
		begin
			if (push)
				wptr <= wptr + 1'b1;
			if (pop)
				rptr <= rptr + 1'b1;
		end
endmodule : qss_fifo
`default_nettype wire

// ---- hw/qss_host.sv ----
// host end: selects channels, triggers sequences at a legal rate and
// reads results during or after each sequence
// assumes the converter end sits on the other side of qss_if
`default_nettype none
module qss_host
	import qss_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        start,
	input  wire logic        sw_mode,
	input  wire logic [3:0]  chan_set,
	input  wire logic        read_after,
	output logic             ready,
	output logic             res_valid,
	output logic [11:0]      res_data,
	qss_if.host              bus
);
	typedef enum logic [2:0] {QH_IDLE, QH_WRITE, QH_TRIG, QH_WAIT, QH_READ,
		QH_ACQ} qh_state_t;

	qh_state_t    state;
	logic [13:0]  s1;
	logic [13:0]  s2;
	logic         eoc_prev;
	logic [8:0]   cnt;
	logic [8:0]   gap;
	logic [2:0]   nread;
	logic [2:0]   neoc;
	logic         single;
	logic         after;
	logic         trig;
	logic         cs_n;
	logic         rd_n;
	logic         wr_n;
	logic         hw_sel;
	logic [3:0]   pins;
	logic         dr_oe;

	wire          busy_s   = s2[13];
	wire          eoc_s    = s2[12];
	wire [11:0]   db_s     = s2[11:0];
	wire          eoc_edge = eoc_s & ~eoc_prev;
	wire [2:0]    nsel     = 3'(chan_set[0]) + 3'(chan_set[1]) + 3'(chan_set[2])
		+ 3'(chan_set[3]);
	wire [8:0]    period   = single ? 9'(SINGLE_CYC) : 9'(QUAD_CYC);
	wire          gap_ok   = gap >= period;
	wire          strobe_lo = cnt < 9'(STROBE_CYC);
	wire          sample_now = cnt == 9'(STROBE_CYC - 1);
	wire          pulse_end = cnt == 9'(2 * STROBE_CYC - 1);

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			s1       <= '0;
			s2       <= '0;
			eoc_prev <= 1'b0;
		end
		else if (ce)
		begin
			s1       <= {bus.busy, bus.eoc, bus.db};
			s2       <= s1;
			eoc_prev <= eoc_s;
		end

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			state     <= QH_IDLE;
			cnt       <= '0;
			gap       <= 9'(QUAD_CYC);
			nread     <= '0;
			neoc      <= '0;
			single    <= 1'b0;
			after     <= 1'b0;
			trig      <= 1'b0;
			cs_n      <= 1'b1;
			rd_n      <= 1'b1;
			wr_n      <= 1'b1;
			hw_sel    <= 1'b1;
			pins      <= CHAN_RST;
			dr_oe     <= 1'b0;
			ready     <= 1'b0;
			res_valid <= 1'b0;
			res_data  <= '0;
		end
		else if (ce)
		begin
			res_valid <= 1'b0;
			if (gap != 9'h1ff)
				gap <= gap + 9'd1;
			unique case (state)
				QH_IDLE:
				begin
					ready <= gap_ok;
					if (start && gap_ok && nsel != 3'd0)
					begin
						ready  <= 1'b0;
						pins   <= chan_set;
						hw_sel <= ~sw_mode;
						nread  <= nsel;
						neoc   <= nsel;
						single <= nsel == 3'd1;
						after  <= read_after;
						cnt    <= '0;
						state  <= sw_mode ? QH_WRITE : QH_TRIG;
					end
				end
				QH_WRITE:
				begin
					cnt   <= cnt + 9'd1;
					cs_n  <= ~strobe_lo;
					wr_n  <= ~strobe_lo;
					dr_oe <= strobe_lo;
					if (pulse_end)
					begin
						cnt   <= '0;
						state <= QH_TRIG;
					end
				end
				QH_TRIG:
				begin
					cnt  <= cnt + 9'd1;
					trig <= cnt < 9'(TRIG_CYC);
					gap  <= '0;
					if (cnt == 9'(TRIG_CYC))
					begin
						cnt   <= '0;
						state <= QH_WAIT;
					end
				end
				QH_WAIT:
					if (eoc_edge)
					begin
						neoc <= neoc - 3'd1;
						if (!after || neoc == 3'd1)
							state <= QH_READ;
					end
				QH_READ:
				begin
					cnt  <= cnt + 9'd1;
					cs_n <= ~strobe_lo;
					rd_n <= ~strobe_lo;
					if (sample_now)
					begin
						res_data  <= db_s;
						res_valid <= 1'b1;
					end
					if (pulse_end)
					begin
						cnt   <= '0;
						nread <= nread - 3'd1;
						if (nread == 3'd1)
							state <= QH_ACQ;
						else if (!after)
							state <= QH_WAIT;
					end
				end
				QH_ACQ:
					if (busy_s)
						cnt <= '0;
					else if (cnt == 9'(ACQ_CYC))
						state <= QH_IDLE;
					else
						cnt <= cnt + 9'd1;
				default:
					state <= QH_IDLE;
			endcase
		end

	assign bus.conversion_trigger = trig;
	assign bus.cs_n               = cs_n;
	assign bus.rd_n               = rd_n;
	assign bus.wr_n               = wr_n;
	assign bus.hw_sel             = hw_sel;
	assign bus.sel_pins           = pins;
	assign bus.db_host            = {8'h00, pins};
	assign bus.db_host_oe         = dr_oe;
endmodule : qss_host
`default_nettype wire

// ---- verification/qss_link_assertions.sv ----
// checker for the converter link: watches the pins of qss_if and the hold outputs
// assumes one clock for both ends; the bench instantiates it beside the link
`default_nettype none
module qss_checker
	import qss_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        conversion_trigger,
	input  wire logic        cs_n,
	input  wire logic        rd_n,
	input  wire logic        hw_sel,
	input  wire logic [3:0]  sel_pins,
	input  wire logic        busy,
	input  wire logic        eoc,
	input  wire logic [11:0] db_dev,
	input  wire logic        db_dev_oe,
	input  wire logic [3:0]  hold
);
	localparam int MAX_BUSY = NCH * (CONV_CYC + 8);
	logic        trig_d;
	logic [15:0] since_trig;
	logic [15:0] since_idle;
	logic [15:0] busy_len;
	wire         trig_rise = conversion_trigger & ~trig_d;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// since_trig and since_idle start full so the first trigger after reset is legal
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			trig_d     <= 1'b0;
			since_trig <= 16'hffff;
			since_idle <= 16'hffff;
			busy_len   <= 16'h0000;
		end
		else
		begin
			trig_d     <= conversion_trigger;
			since_trig <= trig_rise ? 16'h0000 : since_trig + {15'h0000, ~&since_trig};
			since_idle <= busy ? 16'h0000 : since_idle + {15'h0000, ~&since_idle};
			busy_len   <= busy ? busy_len + 16'h0001 : 16'h0000;
		end
	end

	a_trig_to_busy: assert property (trig_rise && hw_sel && sel_pins != 4'h0 && !busy
		|-> ##[2:5] busy) else $error("trigger did not start a sequence");
	a_hold_tracks_busy: assert property (hold == (busy ? 4'hf : 4'h0))
		else $error("hold differs from busy");
	a_eoc_single: assert property (eoc |=> !eoc)
		else $error("eoc longer than one cycle");
	a_eoc_in_seq: assert property (eoc |-> $past(busy))
		else $error("eoc outside a sequence");
	a_busy_end_eoc: assert property ($fell(busy) |-> eoc)
		else $error("busy fell without final eoc");
	a_first_conv: assert property ($rose(busy) |-> ##[1:90] eoc)
		else $error("first conversion too slow");
	a_next_conv: assert property (eoc && busy |=> ##[0:90] eoc)
		else $error("next conversion too slow");
	a_busy_bound: assert property (busy_len <= 16'(MAX_BUSY))
		else $error("sequence too long");
	a_acq_gap: assert property (trig_rise |-> since_idle >= 16'(ACQ_CYC))
		else $error("trigger inside acquisition time");
	a_read_answer: assert property ($fell(rd_n) && !cs_n |-> ##[2:4] db_dev_oe)
		else $error("read not answered");
	a_read_stable: assert property (db_dev_oe && $past(db_dev_oe) |-> $stable(db_dev))
		else $error("read data moved during read");
	a_read_release: assert property ($rose(rd_n) |-> ##[1:4] !db_dev_oe)
		else $error("data bus not released");
	a_single_rate: assert property (trig_rise |-> since_trig >= 16'(SINGLE_CYC - 1))
		else $error("triggers too close");
	a_quad_rate: assert property (trig_rise && hw_sel && sel_pins == 4'hf
		|-> since_trig >= 16'(QUAD_CYC - 1)) else $error("four channel triggers too close");
endmodule : qss_checker
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench: both link ends joined over qss_if, results checked with a queue model
// assumes the converter returns each sampled input code unchanged
`default_nettype none
module tb_top
	import qss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                        clk;
	logic                        nrst;
	logic                        ce;
	logic                        start;
	logic                        sw_mode;
	logic                        read_after;
	logic [3:0]                  chan_set;
	logic [NCH-1:0][DATA_W-1:0]  ain;
	logic [3:0]                  hold;
	logic                        ready;
	logic                        res_valid;
	logic [11:0]                 res_data;
	int                          fail_count = 0;
	int                          n_compared = 0;
	int                          cyc = 0;
	int                          eoc_n = 0;
	int                          seed = 32'hecaae639;
	int                          exp_q[$];

	qss_if qss_if_inst ();
	qss_device qss_device_inst (.clk(clk), .nrst(nrst), .ce(ce), .ain(ain), .hold(hold),
		.bus(qss_if_inst));
	qss_host qss_host_inst (.clk(clk), .nrst(nrst), .ce(ce), .start(start),
		.sw_mode(sw_mode), .chan_set(chan_set), .read_after(read_after), .ready(ready),
		.res_valid(res_valid), .res_data(res_data), .bus(qss_if_inst));
	qss_checker qss_checker_inst (.clk(clk), .nrst(nrst),
		.conversion_trigger(qss_if_inst.conversion_trigger), .cs_n(qss_if_inst.cs_n),
		.rd_n(qss_if_inst.rd_n), .hw_sel(qss_if_inst.hw_sel), .sel_pins(qss_if_inst.sel_pins),
		.busy(qss_if_inst.busy), .eoc(qss_if_inst.eoc), .db_dev(qss_if_inst.db_dev),
		.db_dev_oe(qss_if_inst.db_dev_oe), .hold(hold));

	always #10 clk = ~clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] expect_v);
		n_compared++;
		if (seen !== expect_v)
		begin
			fail_count++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, expect_v);
		end
	endtask : check

	task automatic print_verdict;
		$display("compared %0d, mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic wait_ready(input logic want);
		int n;
		n = 0;
		while (ready !== want && n < 4000)
		begin
			@(negedge clk);
			n++;
		end
		check(16'(ready), 16'(want));
	endtask : wait_ready

	// one sequence: fresh random codes, expected words queued in channel order
	task automatic run_seq(input logic [3:0] set, input logic sw, input logic ra);
		@(negedge clk);
		wait_ready(1'b1);
		for (int i = 0; i < NCH; i++)
		begin
			ain[i] = 12'($random(seed));
			if (set[i])
				exp_q.push_back(int'(ain[i]));
		end
		chan_set = set;
		sw_mode = sw;
		read_after = ra;
		eoc_n = 0;
		start = 1'b1;
		wait_ready(1'b0);
		start = 1'b0;
		wait_ready(1'b1);
		check(16'(eoc_n), 16'($countones(set)));
		check(16'(exp_q.size()), 16'h0000);
	endtask : run_seq

	// outputs change on the rising edge, so they are sampled on the falling one
	always @(negedge clk)
	begin
		cyc++;
		if (qss_if_inst.eoc === 1'b1)
			eoc_n++;
		if (nrst === 1'b1 && res_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(16'h0001, 16'h0000);
			else
				check(16'(res_data), 16'(exp_q.pop_front()));
		end
		if (cyc == 100000)
		begin
			fail_count++;
			print_verdict();
		end
	end

	initial
	begin
		clk = 1'b0;
		nrst = 1'b0;
		ce = 1'b1;
		start = 1'b0;
		sw_mode = 1'b0;
		read_after = 1'b0;
		chan_set = 4'h0;
		ain = '0;
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		// an empty channel set must not start anything
		wait_ready(1'b1);
		start = 1'b1;
		repeat (30) @(negedge clk);
		check(16'(qss_if_inst.busy), 16'h0000);
		check(16'(ready), 16'h0001);
		start = 1'b0;
		// every non-empty subset, pin and register selection, both read schemes
		for (int s = 1; s < 16; s++)
			for (int m = 0; m < 4; m++)
				run_seq(4'(s), m[1], m[0]);
		// reset in mid-sequence, then recovery
		chan_set = 4'hf;
		sw_mode = 1'b0;
		start = 1'b1;
		wait_ready(1'b0);
		start = 1'b0;
		eoc_n = 0;
		// freeze both ends across the first conversion end: the pulse must wait
		repeat (84) @(negedge clk);
		ce = 1'b0;
		repeat (5) @(negedge clk);
		check(16'(eoc_n), 16'h0000);
		check(16'(qss_if_inst.busy), 16'h0001);
		check(16'(hold), 16'h000f);
		ce = 1'b1;
		repeat (6) @(negedge clk);
		check(16'(eoc_n), 16'h0001);
		repeat (55) @(negedge clk);
		nrst = 1'b0;
		@(negedge clk);
		check(16'(qss_if_inst.busy), 16'h0000);
		check(16'(hold), 16'h0000);
		repeat (15) @(negedge clk);
		exp_q.delete();
		nrst = 1'b1;
		run_seq(4'h5, 1'b1, 1'b0);
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
